//--- logic/bidir_port_with_pullups.sv
/*
  eight-pin bidirectional port with data latch, direction and pullup enable registers,
  shared with a keypad interrupt unit and an analog converter.
  assumes an avalon-mm master on clk, pins resolved by the bench from the enables,
  and keypad/converter control levels coming from logic on the same clock.
*/
// Overview of operation
// - eight pins, each also usable by keypad unit and analog channels
// - one read/write latch bit per pin, untouched by reset
// - direction bit 1 drives the pin, 0 makes it an input
// - reset clears all direction bits so every pin is input
// - data read gives latch value for output pins
// - data read gives synchronised pin level for input pins
// - data write with byteenable bit 0 set always updates latch; input readback unaffected
// - plain pullup active only when enabled and pin is a digital non-keypad input
// - pullup enable 1 connects pullup, 0 leaves input high impedance (non-keypad pins only)
// - keypad pin enable routes pin level to keypad unit
// - converter channel select forces pin to analog input, overriding all control
// - keypad input pins get pullup or pulldown from keypad polarity
`timescale 1ns/1ps
module bidir_port_with_pullups
  import gpio_port_pkg::*;
#(
  parameter int WIDTH = gpio_port_pkg::PORT_WIDTH
) (
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic [gpio_port_pkg::ADDR_WIDTH-1:0] avs_address,
  input  wire logic                              avs_read,
  input  wire logic                              avs_write,
  input  wire logic [31:0]                       avs_writedata,
  input  wire logic [3:0]                        avs_byteenable,
  output logic      [31:0]                       avs_readdata,
  output logic                                   avs_waitrequest,
  input  wire logic [WIDTH-1:0]                  pin_in,
  output logic      [WIDTH-1:0]                  pin_out,
  output logic      [WIDTH-1:0]                  pin_oe,
  output logic      [WIDTH-1:0]                  pin_pullup,
  output logic      [WIDTH-1:0]                  pin_pulldown,
  output logic      [WIDTH-1:0]                  pin_analog,
  input  wire logic [WIDTH-1:0]                  keypad_pin_enables,
  input  wire logic [WIDTH-1:0]                  keypad_polarity_reg,
  input  wire logic [WIDTH-1:0]                  analog_channel_select,
  output logic      [WIDTH-1:0]                  keypad_inputs,
  output logic      [WIDTH-1:0]                  analog_channel_inputs
);
  initial begin
    if (WIDTH < 1 || WIDTH > 8) begin
      $error("port width must be 1 to 8");
    end
  end

  logic [WIDTH-1:0] port_data_latch;
  logic [WIDTH-1:0] port_direction;
  logic [WIDTH-1:0] port_pullup_enable;
  logic [WIDTH-1:0] pin_level;
  logic             answered;

  // answer one cycle after the request appears
  wire req       = avs_read | avs_write;
  wire accept    = req & answered;
  wire wr_take   = accept & avs_write & avs_byteenable[0];
  wire sel_data  = (avs_address == OFS_DATA);
  wire sel_dir   = (avs_address == OFS_DIRECTION);
  wire sel_pull  = (avs_address == OFS_PULLUP);
  wire sel_pins  = (avs_address == OFS_PIN_STATUS);
  wire [WIDTH-1:0] wr_byte = avs_writedata[WIDTH-1:0];

  assign avs_waitrequest = req & ~answered;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      answered <= 1'b0;
    end else begin
      answered <= req & ~answered;
    end
  end

  pin_sync #(
    .WIDTH  (WIDTH),
    .STAGES (SYNC_STAGES)
  ) u_pin_sync (
    .clk      (clk),
    .arst_n   (arst_n),
    .async_in (pin_in),
    .sync_out (pin_level)
  );

  // latch has no reset so its content survives system reset
  always_ff @(posedge clk) begin
    if (wr_take && sel_data) begin
      port_data_latch <= wr_byte;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_direction     <= DIRECTION_RESET[WIDTH-1:0];
      port_pullup_enable <= PULLUP_RESET[WIDTH-1:0];
    end else begin
      if (wr_take && sel_dir) begin
        port_direction <= wr_byte;
      end
      if (wr_take && sel_pull) begin
        port_pullup_enable <= wr_byte;
      end
    end
  end

  // converter selection overrides direction, latch and pullup
  wire [WIDTH-1:0] digital     = ~analog_channel_select;
  wire [WIDTH-1:0] keypad_used = keypad_pin_enables & digital & ~port_direction;
  wire [WIDTH-1:0] data_view   = (port_direction & port_data_latch) | (~port_direction & pin_level);
  wire [WIDTH-1:0] plain_pull  = port_pullup_enable & ~port_direction & digital & ~keypad_used;

  assign pin_oe                = port_direction & digital;
  assign pin_out               = port_data_latch & pin_oe;
  assign pin_analog            = analog_channel_select;
  assign analog_channel_inputs = analog_channel_select;
  assign pin_pullup            = plain_pull | (keypad_used & ~keypad_polarity_reg);
  assign pin_pulldown          = keypad_used & keypad_polarity_reg;
  assign keypad_inputs         = pin_level & keypad_pin_enables & digital;

  wire [WIDTH-1:0] rd_mux = sel_data ? data_view :
                            sel_dir  ? port_direction :
                            sel_pull ? port_pullup_enable :
                            sel_pins ? pin_level : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req && !answered) begin
      avs_readdata <= {{(32-WIDTH){1'b0}}, rd_mux};
    end
  end
endmodule

//--- logic/gpio_port_pkg.sv
/*
  constants for the eight-pin bidirectional port: register offsets, widths, reset values.
  assumes a 32-bit avalon-mm register bus with byte addresses.
*/
package gpio_port_pkg;
  localparam int          PORT_WIDTH      = 8;
  localparam int          ADDR_WIDTH      = 4;
  localparam logic [3:0]  OFS_DATA        = 4'h0;
  localparam logic [3:0]  OFS_DIRECTION   = 4'h4;
  localparam logic [3:0]  OFS_PULLUP      = 4'h8;
  localparam logic [3:0]  OFS_PIN_STATUS  = 4'hc;
  localparam logic [7:0]  DIRECTION_RESET = 8'h00;
  localparam logic [7:0]  PULLUP_RESET    = 8'h00;
  localparam int          SYNC_STAGES     = 2;
endpackage

//--- logic/pin_sync.sv
/*
  multi-stage synchroniser for a vector of pin levels.
  assumes the inputs are asynchronous to clk; only the last stage is read outside.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH  = 8,
  parameter int STAGES = 2
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage [STAGES];

  initial begin
    if (STAGES < 2) begin
      $error("pin_sync needs at least two stages");
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= '0;
      end
    end else begin
      stage[0] <= async_in;
      for (int i = 1; i < STAGES; i++) begin
        stage[i] <= stage[i-1];
      end
    end
  end

  assign sync_out = stage[STAGES-1];
endmodule

//--- test/pin_model.sv
/* external pins: resolves each pin level from the port's drives and the bench's drive.
   assumes a floating pin reads as a pattern changing every cycle */
`timescale 1ns/1ps
module pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] pin_pulldown,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_level
);
  logic [7:0] flip;
  initial begin
    flip = 8'h55;
  end
  always @(posedge clk) begin
    flip <= ~flip;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_level[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                     pin_pullup[i] ? 1'b1 : pin_pulldown[i] ? 1'b0 : flip[i];
    end
  end
endmodule

//--- test/port_sva.sv
/* checker on the port's pins and bus handshake. assumes bind to the top module */
`timescale 1ns/1ps
module port_sva (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       avs_read,
  input wire logic       avs_waitrequest,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] pin_pulldown,
  input wire logic [7:0] pin_analog,
  input wire logic [7:0] keypad_pin_enables,
  input wire logic [7:0] keypad_polarity_reg,
  input wire logic [7:0] analog_channel_select,
  input wire logic [7:0] keypad_inputs
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  analog_no_drive_a: assert property ((pin_oe & analog_channel_select) == 8'h00) else $error("analog pin driven");
  analog_mirror_a: assert property (pin_analog == analog_channel_select) else $error("analog select lost");
  pullup_input_a: assert property ((pin_pullup & pin_oe) == 8'h00) else $error("pullup on output");
  pulldown_kbd_a: assert property ((pin_pulldown & ~(keypad_pin_enables & keypad_polarity_reg)) == 8'h00)
    else $error("stray pulldown");
  kbd_gate_a: assert property ((keypad_inputs & ~keypad_pin_enables) == 8'h00) else $error("keypad leak");
  kbd_sync_a: assert property ($past(arst_n, 2) |-> keypad_inputs ==
    ($past(pin_in, 2) & keypad_pin_enables & ~analog_channel_select)) else $error("sync latency");
  wait_first_a: assert property ($rose(avs_read) |-> avs_waitrequest) else $error("no wait cycle");
  wait_one_a: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("long wait");
endmodule
bind bidir_port_with_pullups port_sva u_sva (.*);

//--- test/bidir_port_with_pullups_tb.sv
/* testbench for the port. assumes pin_model as the pins and port_sva bound to the top */
`timescale 1ns/1ps
module bidir_port_with_pullups_tb;
  import gpio_port_pkg::*;
  logic clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'h1;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, keypad_inputs, aci, q, pan;
  logic [7:0] keypad_pin_enables = 8'h00, keypad_polarity_reg = 8'h00, analog_channel_select = 8'h00;
  logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
  int compares = 0, miscompares = 0;
  bidir_port_with_pullups uut (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .pin_pulldown, .pin_analog(pan), .keypad_pin_enables, .keypad_polarity_reg, .analog_channel_select,
    .keypad_inputs, .analog_channel_inputs(aci));
  pin_model pm (.clk, .pin_out, .pin_oe, .pin_pullup, .pin_pulldown, .ext_en, .ext_val, .pin_level(pin_in));
  initial forever #5 clk = ~clk;
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task t_io;
    ext_en <= 8'hf0;
    ext_val <= 8'h30;
    bus(1, OFS_DATA, 8'ha5, q);
    bus(1, OFS_DIRECTION, 8'h0f, q);
    @(negedge clk);
    chk("oe", pin_oe, 8'h0f);
    chk("out", pin_out, 8'h05);
    bus(0, OFS_DATA, 0, q); chk("rd", q, 8'h35);
    bus(1, OFS_DATA, 8'hff, q);
    bus(0, OFS_DATA, 0, q); chk("rd2", q, 8'h3f);
    $display("t_io done");
  endtask
  task t_pull;
    ext_en <= 8'h00;
    keypad_pin_enables <= 8'h30;
    keypad_polarity_reg <= 8'h20;
    bus(1, OFS_PULLUP, 8'hff, q);
    @(negedge clk);
    chk("pu", pin_pullup, 8'hd0);
    chk("pd", pin_pulldown, 8'h20);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("kbd", keypad_inputs, 8'h10);
    bus(0, OFS_DATA, 0, q); chk("rd3", q, 8'hdf);
    analog_channel_select <= 8'h81;
    @(negedge clk);
    chk("aoe", pin_oe, 8'h0e);
    chk("aci", aci, 8'h81);
    chk("pan", pan, 8'h81);
    chk("pua", pin_pullup, 8'h50);
    chk("pda", pin_pulldown, 8'h20);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("kbda", keypad_inputs, 8'h10);
    @(posedge clk) analog_channel_select <= 8'h00;
    $display("t_pull done");
  endtask
  initial begin
    #100us;
    miscompares++;
    finish_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, OFS_DIRECTION, 0, q); chk("dir", q, DIRECTION_RESET);
    bus(0, OFS_PULLUP, 0, q); chk("pue", q, PULLUP_RESET);
    bus(0, 4'h2, 0, q); chk("unmapped", q, 8'h00);
    t_io;
    t_pull;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    bus(0, OFS_DIRECTION, 0, q); chk("dir2", q, 8'h00);
    bus(1, OFS_DIRECTION, 8'hff, q);
    bus(0, OFS_DATA, 0, q); chk("latch", q, 8'hff);
    $display("t_reset done");
    finish_test;
  end
endmodule
